// ### sim/rpir_regs_chk.sv
// Port-level assertions for the isolation/partition register block
`timescale 1ns/100ps
module rpir_regs_chk (
  input wire logic       ref_clk,
  input wire logic       arst_n,
  input wire logic       mdc,
  input wire logic       mdio_in,
  input wire logic       mdio_out,
  input wire logic       mdio_oe,
  input wire logic [7:0] link_good,
  input wire logic [7:0] cut_off,
  input wire logic [7:0] isolation_off,
  input wire logic [7:0] partition_off
);
  logic [4:0] falls;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  sequence s_high2; mdc ##1 mdc; endsequence
  sequence s_after_rise; $past(mdc) && !$past(mdc, 3); endsequence
  // Counts mdc falls while the device drives the data line
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      falls <= 5'h00;
    end else begin
      falls <= !mdio_oe ? 5'h00 : falls + (($past(mdc) && !mdc) ? 5'h01 : 5'h00);
    end
  end
  chk_oe_on_fall: assert property ($changed(mdio_oe) |-> !$past(mdc))
    else $error("drive enable moved outside mdc low");
  chk_out_on_fall: assert property (mdio_oe && $changed(mdio_out) |-> !$past(mdc))
    else $error("read data moved outside mdc low");
  chk_quiet_high: assert property (s_high2 |-> $stable(mdio_oe) && (!mdio_oe || $stable(mdio_out)))
    else $error("data line moved while mdc high");
  chk_ta_zero: assert property ($rose(mdio_oe) |-> !mdio_out)
    else $error("turnaround bit not zero");
  chk_drive_len: assert property ($fell(mdio_oe) |-> falls == 5'h11)
    else $error("read drive length wrong");
  chk_iso_write: assert property ($changed(isolation_off) |-> s_after_rise)
    else $error("isolation bits moved off a write");
  chk_part_write: assert property ($changed(partition_off) |-> s_after_rise)
    else $error("partition bits moved off a write");
  chk_reset_clear: assert property (disable iff (1'b0) !arst_n |-> !isolation_off && !partition_off && !mdio_oe)
    else $error("outputs not cleared in reset");
endmodule
bind rpir_regs rpir_regs_chk u_rpir_regs_chk (.ref_clk, .arst_n, .mdc, .mdio_in, .mdio_out, .mdio_oe,
  .link_good, .cut_off, .isolation_off, .partition_off);

// ### sim/rpir_regs_test.sv
// Self-checking bench for the isolation/partition management registers
`timescale 1ns/100ps
module rpir_regs_test;
  localparam logic [4:0] PHY = 5'h03;
  logic       ref_clk = 1'b0;
  logic       arst_n, mdc, mdio, dut_out, dut_oe, st_out, st_oe;
  logic [7:0] link_good, cut_off, isolation_off, partition_off;
  int         errors = 0;
  int         tests_run = 0;
  always #5 ref_clk = ~ref_clk;
  // Pull-up when nobody drives
  assign mdio = dut_oe ? dut_out : (st_oe ? st_out : 1'b1);
  rpir_regs #(.PHY_ADDR(PHY)) u_rpir_regs (.ref_clk, .arst_n, .mdc, .mdio_in(mdio), .mdio_out(dut_out),
    .mdio_oe(dut_oe), .link_good, .cut_off, .isolation_off, .partition_off);
  rpir_station u_rpir_station (.ref_clk, .mdio, .mdc, .st_out, .st_oe);
  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] phy, input logic [4:0] ra, input logic [15:0] wd);
    logic [17:0] r;
    u_rpir_station.xfer(phy, rpir_pkg::OP_WRITE, ra, wd, r);
  endtask
  task automatic rdc(input logic [4:0] phy, input logic [4:0] ra, input logic [17:0] exp);
    logic [17:0] r;
    u_rpir_station.xfer(phy, rpir_pkg::OP_READ, ra, 16'h0000, r);
    chk(r, exp);
  endtask
  task automatic t_after_reset;
    chk({2'h0, isolation_off, partition_off}, 18'h00000);
    rdc(PHY, rpir_pkg::REG_ISOLATION_OFF, {2'h2, rpir_pkg::ISOLATION_OFF_RST});
    rdc(PHY, rpir_pkg::REG_PARTITION_OFF, {2'h2, rpir_pkg::PARTITION_OFF_RST});
  endtask
  task automatic t_write_back;
    wr(PHY, rpir_pkg::REG_ISOLATION_OFF, 16'h5AA5);
    wr(PHY, rpir_pkg::REG_PARTITION_OFF, 16'hC33C);
    chk({2'h0, isolation_off, partition_off}, 18'h0A53C);
    rdc(PHY, rpir_pkg::REG_PARTITION_OFF, 18'h2C33C);
    wr(PHY, rpir_pkg::REG_ISOLATION_OFF, 16'hFFA5);
    chk({2'h0, isolation_off, partition_off}, 18'h0A53C);
    rdc(PHY, rpir_pkg::REG_ISOLATION_OFF, 18'h2FFA5);
  endtask
  task automatic t_status;
    logic [17:0] r;
    link_good <= 8'h96;
    cut_off <= 8'h69;
    rdc(PHY, rpir_pkg::REG_LINK_STATE, 18'h20096);
    rdc(PHY, rpir_pkg::REG_PARTITION_STAT, 18'h20069);
    // Read word is captured at edge 286 of a frame; link moves 2 edges before it, partition 5 before it
    fork
      u_rpir_station.xfer(PHY, rpir_pkg::OP_READ, rpir_pkg::REG_LINK_STATE, 16'h0000, r);
      begin
        repeat (284) @(posedge ref_clk);
        link_good <= 8'h5A;
      end
    join
    chk(r, 18'h2005A);
    fork
      u_rpir_station.xfer(PHY, rpir_pkg::OP_READ, rpir_pkg::REG_PARTITION_STAT, 16'h0000, r);
      begin
        repeat (281) @(posedge ref_clk);
        cut_off <= 8'hA5;
      end
    join
    chk(r, 18'h200A5);
  endtask
  task automatic t_refused;
    wr(PHY, rpir_pkg::REG_LINK_STATE, 16'hFFFF);
    rdc(PHY, rpir_pkg::REG_LINK_STATE, 18'h2005A);
    wr(PHY ^ 5'h01, rpir_pkg::REG_ISOLATION_OFF, 16'h0000);
    chk({2'h0, isolation_off, partition_off}, 18'h0A53C);
    rdc(PHY, 5'h15, 18'h20000);
    rdc(PHY ^ 5'h01, rpir_pkg::REG_ISOLATION_OFF, 18'h3FFFF);
  endtask
  task automatic summarize;
    if (errors == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk);
    errors++;
    summarize();
  end
  initial begin
    arst_n <= 1'b0;
    link_good <= 8'h00;
    cut_off <= 8'h00;
    for (int k = 0; k < 2; k++) begin
      repeat (4) @(posedge ref_clk);
      arst_n <= 1'b1;
      @(posedge ref_clk);
      t_after_reset();
      t_write_back();
      if (k == 0) begin
        t_status();
        t_refused();
      end
      arst_n <= 1'b0;
    end
    summarize();
  end
endmodule

// ### sim/rpir_station.sv
// Management station model: makes mdc, sends frames, samples the resolved data line
`timescale 1ns/100ps
module rpir_station (
  input  wire logic ref_clk,
  input  wire logic mdio,
  output logic      mdc,
  output logic      st_out,
  output logic      st_oe
);
  initial begin
    mdc = 1'b0;
    st_out = 1'b1;
    st_oe = 1'b0;
  end
  // Returns the last 18 bits seen on the line, turnaround first
  task automatic xfer(input logic [4:0] phy, input logic [1:0] op, input logic [4:0] ra,
                      input logic [15:0] wd, output logic [17:0] rd);
    logic [63:0] fr;
    fr = {32'hFFFFFFFF, 2'h1, op, phy, ra, 2'h2, wd};
    rd = 18'h00000;
    for (int i = 63; i >= 0; i--) begin
      mdc <= 1'b0;
      st_oe <= !(op == rpir_pkg::OP_READ && i < 18);
      st_out <= fr[i];
      repeat (3) @(posedge ref_clk);
      mdc <= 1'b1;
      rd = {rd[16:0], mdio};
      repeat (3) @(posedge ref_clk);
    end
    mdc <= 1'b0;
    st_oe <= 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask
endmodule

// ### verilog/rpir_pkg.sv
// Constants, types and field layout of the per-port isolation and partition management registers
package rpir_pkg;

  localparam int PORTS  = 8;
  localparam int DATA_W = 16;

  // Register numbers on the management interface
  localparam logic [4:0] REG_ISOLATION_OFF  = 5'h13;
  localparam logic [4:0] REG_PARTITION_OFF  = 5'h14;
  localparam logic [4:0] REG_LINK_STATE     = 5'h19;
  localparam logic [4:0] REG_PARTITION_STAT = 5'h1A;

  // Field positions: port bits low, kept-only bits high
  localparam int PORT_LSB  = 0;
  localparam int UPPER_LSB = 8;

  localparam logic [15:0] ISOLATION_OFF_RST = 16'h0000;
  localparam logic [15:0] PARTITION_OFF_RST = 16'h0000;

  // Management frame fields
  localparam logic [1:0] OP_WRITE  = 2'h1;
  localparam logic [1:0] OP_READ   = 2'h2;
  localparam logic [5:0] PRE_BITS  = 6'h20;
  localparam logic [5:0] HDR_LAST  = 6'h0B;
  localparam logic [5:0] TA_LAST   = 6'h01;
  localparam logic [5:0] DATA_LAST = 6'h0F;

  // Device address on the management bus; value is arbitrary
  localparam logic [4:0] PHY_ADDR_DEF = 5'h00;

  // Partition state sampling interval
  localparam int CLK_NS         = 10;
  localparam int CUT_SAMPLE_NS  = 40;
  localparam int CUT_SAMPLE_CYC = (CUT_SAMPLE_NS / CLK_NS < 1) ? 1 : CUT_SAMPLE_NS / CLK_NS;

  typedef enum logic [5:0] {
    S_PRE  = 6'h01,
    S_ST   = 6'h02,
    S_HDR  = 6'h04,
    S_TA   = 6'h08,
    S_RD   = 6'h10,
    S_DIN  = 6'h20
  } rpir_state_t;

  typedef struct packed {
    logic [1:0] op;
    logic [4:0] phy;
    logic [4:0] regad;
  } rpir_hdr_t;

endpackage

// ### verilog/rpir_regs.sv
// Per-port isolation/partition management registers behind a serial management slave
`timescale 1ns/100ps
module rpir_regs #(
  parameter logic [4:0] PHY_ADDR = rpir_pkg::PHY_ADDR_DEF
) (
  input  wire logic       ref_clk,
  input  wire logic       arst_n,
  input  wire logic       mdc,
  input  wire logic       mdio_in,
  output logic            mdio_out,
  output logic            mdio_oe,
  input  wire logic [7:0] link_good,
  input  wire logic [7:0] cut_off,
  output logic      [7:0] isolation_off,
  output logic      [7:0] partition_off
);

  rpir_pkg::rpir_state_t state;
  rpir_pkg::rpir_state_t next_state;
  rpir_pkg::rpir_hdr_t   hdr;
  rpir_pkg::rpir_hdr_t   next_hdr;
  logic [5:0]            cnt;
  logic [5:0]            next_cnt;
  logic [15:0]           shreg;
  logic [15:0]           next_shreg;
  logic [15:0]           iso_reg;
  logic [15:0]           next_iso_reg;
  logic [15:0]           part_reg;
  logic [15:0]           next_part_reg;
  logic                  mdc_q;
  logic                  next_mdio_out;
  logic                  next_mdio_oe;
  logic [7:0]            link_q;
  logic [7:0]            cut_q;
  logic [7:0]            next_cut_q;
  logic [2:0]            samp_cnt;
  logic [2:0]            next_samp_cnt;
  logic                  mdc_rise;
  logic                  mdc_fall;
  logic                  addr_hit;
  logic                  rd_hit;

  // Read data word for a register number; unmapped numbers read zero
  function automatic logic [15:0] rd_word(input logic [4:0] regad, input logic [15:0] iso,
                                          input logic [15:0] part, input logic [7:0] link,
                                          input logic [7:0] cut);
    logic [15:0] w;
    w = 16'h0000;
    unique case (regad)
      rpir_pkg::REG_ISOLATION_OFF:  w = iso;
      rpir_pkg::REG_PARTITION_OFF:  w = part;
      rpir_pkg::REG_LINK_STATE:     w = {8'h00, link};
      rpir_pkg::REG_PARTITION_STAT: w = {8'h00, cut};
      default:                      w = 16'h0000;
    endcase
    return w;
  endfunction

  assign mdc_rise = mdc & ~mdc_q;
  assign mdc_fall = ~mdc & mdc_q;
  assign addr_hit = (hdr.phy == PHY_ADDR);
  assign rd_hit   = addr_hit && (hdr.op == rpir_pkg::OP_READ);

  // Frame decoder and writable registers
  always_comb begin
    next_state    = state;
    next_cnt      = cnt;
    next_hdr      = hdr;
    next_shreg    = shreg;
    next_iso_reg  = iso_reg;
    next_part_reg = part_reg;
    if (mdc_rise) begin
      unique case (state)
        rpir_pkg::S_PRE: begin
          if (mdio_in) begin
            if (cnt < rpir_pkg::PRE_BITS) begin
              next_cnt = cnt + 6'h01;
            end
          end else begin
            if (cnt >= rpir_pkg::PRE_BITS) begin
              next_state = rpir_pkg::S_ST;
            end
            next_cnt = 6'h00;
          end
        end
        rpir_pkg::S_ST: begin
          next_state = mdio_in ? rpir_pkg::S_HDR : rpir_pkg::S_PRE;
          next_cnt   = 6'h00;
        end
        rpir_pkg::S_HDR: begin
          next_hdr = rpir_pkg::rpir_hdr_t'({hdr[10:0], mdio_in});
          next_cnt = cnt + 6'h01;
          if (cnt == rpir_pkg::HDR_LAST) begin
            next_state = rpir_pkg::S_TA;
            next_cnt   = 6'h00;
          end
        end
        rpir_pkg::S_TA: begin
          next_cnt = cnt + 6'h01;
          if (cnt == rpir_pkg::TA_LAST) begin
            next_cnt = 6'h00;
            if (rd_hit) begin
              next_state = rpir_pkg::S_RD;
              next_shreg = rd_word(hdr.regad, iso_reg, part_reg, link_q, cut_q);
            end else begin
              // Foreign or odd frames are soaked up so their data never looks like preamble
              next_state = rpir_pkg::S_DIN;
            end
          end
        end
        rpir_pkg::S_RD: begin
          next_shreg = {shreg[14:0], 1'b0};
          next_cnt   = cnt + 6'h01;
          if (cnt == rpir_pkg::DATA_LAST) begin
            next_state = rpir_pkg::S_PRE;
            next_cnt   = 6'h00;
          end
        end
        rpir_pkg::S_DIN: begin
          next_shreg = {shreg[14:0], mdio_in};
          next_cnt   = cnt + 6'h01;
          if (cnt == rpir_pkg::DATA_LAST) begin
            next_state = rpir_pkg::S_PRE;
            next_cnt   = 6'h00;
            if (addr_hit && hdr.op == rpir_pkg::OP_WRITE) begin
              // Only the two off registers take writes; link and partition state ignore them
              if (hdr.regad == rpir_pkg::REG_ISOLATION_OFF) begin
                next_iso_reg = {shreg[14:0], mdio_in};
              end
              if (hdr.regad == rpir_pkg::REG_PARTITION_OFF) begin
                next_part_reg = {shreg[14:0], mdio_in};
              end
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state    <= rpir_pkg::S_PRE;
      cnt      <= 6'h00;
      hdr      <= '0;
      shreg    <= 16'h0000;
      iso_reg  <= rpir_pkg::ISOLATION_OFF_RST;
      part_reg <= rpir_pkg::PARTITION_OFF_RST;
    end else begin
      state    <= next_state;
      cnt      <= next_cnt;
      hdr      <= next_hdr;
      shreg    <= next_shreg;
      iso_reg  <= next_iso_reg;
      part_reg <= next_part_reg;
    end
  end

  // Data line driver: changes on the falling clock edge so the station samples on the rising one
  always_comb begin
    next_mdio_out = mdio_out;
    next_mdio_oe  = mdio_oe;
    if (mdc_fall) begin
      if (state == rpir_pkg::S_RD) begin
        next_mdio_out = shreg[15];
        next_mdio_oe  = 1'b1;
      end else if (state == rpir_pkg::S_TA && cnt == rpir_pkg::TA_LAST && rd_hit) begin
        next_mdio_out = 1'b0;
        next_mdio_oe  = 1'b1;
      end else begin
        next_mdio_out = 1'b0;
        next_mdio_oe  = 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      mdc_q    <= 1'b0;
      mdio_out <= 1'b0;
      mdio_oe  <= 1'b0;
    end else begin
      mdc_q    <= mdc;
      mdio_out <= next_mdio_out;
      mdio_oe  <= next_mdio_oe;
    end
  end

  // Port status capture
  always_comb begin
    next_samp_cnt = samp_cnt + 3'h1;
    next_cut_q    = cut_q;
    if (samp_cnt == 3'(rpir_pkg::CUT_SAMPLE_CYC - 1)) begin
      next_samp_cnt = 3'h0;
      next_cut_q    = cut_off;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      link_q   <= 8'h00;
      cut_q    <= 8'h00;
      samp_cnt <= 3'h0;
    end else begin
      link_q   <= link_good;
      cut_q    <= next_cut_q;
      samp_cnt <= next_samp_cnt;
    end
  end

  // Only the low port bits steer the port logic; upper bits are storage only
  assign isolation_off = iso_reg[rpir_pkg::PORT_LSB +: rpir_pkg::PORTS];
  assign partition_off = part_reg[rpir_pkg::PORT_LSB +: rpir_pkg::PORTS];

endmodule
